//--- smc_core.sv
/*
 * Stall detection, drive amplitude compensation and 8-bit serial slave.
 * Assumes bridge state, speed and configuration come from same-clock
 * logic; serial pins are asynchronous and are oversampled by mclk_i.
 */
// Behaviour
// - Sensed voltage over threshold drives that bridge's stall flag low.
// - Flag stays low until voltage drops and a status read follows.
// - Threshold is one of 32 levels, 31.25 mV steps up to 1 V.
// - Comparator off when half-bridge is high impedance or low side off.
// - Comparator off while commutating and until blanking has elapsed.
// - Low-speed optimisation only active between zero and minimum speed.
// - With optimisation enabled, profile minimum speed reads as zero.
// - Back-EMF term uses start slope below intersect, final slope above.
// - Separate final slopes for acceleration and deceleration.
// - Constant speed uses acceleration curve; stopped adds no term.
// - ADC result sampled once per PWM period, always.
// - Supply compensation uses ADC only when enabled.
// - Duty value is multiplied by the thermal factor.
// - Serial frames are 8 bits; host is master, device slave.
// - Serial output is high impedance while chip select is high.
// - Input taken MSB first on each rising serial clock edge.
// - Reply shifted out MSB first, updated on falling clock edges.
// - With nothing pending, an all-zero byte is shifted out.
// - While deselected, decode the byte and load any reply.
// - Several devices chain on shared select and clock lines; here any frame other than 8 clocks is refused.
// - Amplitude = (base + bemf) * supply * thermal * microstep.
`timescale 1ns/10ps
module smc_core (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire smc_pkg::smc_bridge_type bridge_i,
   input wire logic [smc_pkg::STALL_TH_W-1:0] stall_th_i,
   input wire logic [smc_pkg::BLANK_SEL_W-1:0] blank_sel_i,
   input wire smc_pkg::smc_amp_cfg_type amp_cfg_i,
   input wire smc_pkg::smc_phase_type phase_i,
   input wire logic pwm_period_i,
   input wire logic [smc_pkg::ADC_W-1:0] adc_code_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_ck_i,
   input wire logic spi_sdi_i,
   input wire logic reply_load_i,
   input wire logic [7:0] reply_byte_i,
   output logic stall_a_n_o,
   output logic stall_b_n_o,
   output logic [smc_pkg::MIN_SPEED_W-1:0] profile_min_speed_o,
   output logic low_speed_opt_active_o,
   output logic [smc_pkg::KVAL_W-1:0] bemf_term_o,
   output logic [smc_pkg::ADC_W-1:0] adc_out_o,
   output logic [5:0] supply_comp_factor_o,
   output logic [smc_pkg::KVAL_W-1:0] drive_amp_o,
   output logic spi_sdo_o,
   output logic spi_sdo_oe_n_o,
   output logic [7:0] rx_byte_o,
   output logic rx_valid_o
);
   localparam int HB = smc_pkg::HALF_BRIDGES;

   // One bit wider: the top level lies just past the sensed range
   function automatic logic [smc_pkg::VDS_W:0] stall_level(
      input logic [smc_pkg::STALL_TH_W-1:0] th);
      return ({4'h0, th} + 9'h001) * 9'(smc_pkg::VDS_LSB_PER_STEP);
   endfunction

   function automatic logic [smc_pkg::KVAL_W-1:0] bemf_curve(
      input logic [smc_pkg::SPEED_W-1:0] spd,
      input logic [smc_pkg::INT_SPEED_W-1:0] isp,
      input logic [smc_pkg::KVAL_W-1:0] st,
      input logic [smc_pkg::KVAL_W-1:0] fn);
      logic [29:0] acc;
      logic [29:0] scaled;
      if (spd < {6'h00, isp})
         acc = 30'(spd) * 30'(st);
      else
         acc = 30'(isp) * 30'(st) + 30'(spd - {6'h00, isp}) * 30'(fn);
      scaled = acc >> smc_pkg::BEMF_SHIFT;
      if (scaled > 30'(smc_pkg::KVAL_MAX))
         return smc_pkg::KVAL_MAX;
      return scaled[smc_pkg::KVAL_W-1:0];
   endfunction

   // Stall comparators with blanking
   logic [HB-1:0][smc_pkg::BLANK_CNT_W-1:0] blank_r;
   logic [HB-1:0] cmp_en;
   logic [HB-1:0] over;
   logic raw_a;
   logic raw_b;
   logic [smc_pkg::BLANK_CNT_W-1:0] blank_len;
   logic stall_a_n_r;
   logic stall_b_n_r;
   logic status_clear;

   assign blank_len = smc_pkg::BLANK_CNT_W'(
      ({3'h0, blank_sel_i} + 6'h01) * 6'(smc_pkg::BLANK_STEP_CYC));

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
         blank_r <= '0;
      else
         for (int i = 0; i < HB; i++)
         begin
            if (bridge_i.commut[i])
               blank_r[i] <= blank_len;
            else if (blank_r[i] != '0)
               blank_r[i] <= blank_r[i] - 6'h01;
         end
   end

   always_comb
   begin
      for (int i = 0; i < HB; i++)
      begin
         cmp_en[i] = !bridge_i.hiz[i] && bridge_i.ls_on[i]
            && !bridge_i.commut[i] && blank_r[i] == '0;
         over[i] = cmp_en[i] &&
            {1'b0, bridge_i.vds[i]} > stall_level(stall_th_i);
      end
   end

   assign raw_a = over[0] | over[1];
   assign raw_b = over[2] | over[3];

   // Detection wins over a clear in the same cycle
   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         stall_a_n_r <= 1'b1;
         stall_b_n_r <= 1'b1;
      end
      else
      begin
         if (raw_a)
            stall_a_n_r <= 1'b0;
         else if (status_clear)
            stall_a_n_r <= 1'b1;
         if (raw_b)
            stall_b_n_r <= 1'b0;
         else if (status_clear)
            stall_b_n_r <= 1'b1;
      end
   end

   assign stall_a_n_o = stall_a_n_r;
   assign stall_b_n_o = stall_b_n_r;

   chk_stall_set: assert property (@(posedge mclk_i) disable iff (reset_i)
      raw_a |=> !stall_a_n_r) else $error("stall A not flagged");
   chk_stall_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
      (!stall_b_n_r && raw_b) |=> !stall_b_n_r)
      else $error("stall B released early");
   chk_blank_off: assert property (@(posedge mclk_i) disable iff (reset_i)
      $fell(bridge_i.commut[2]) |->
      !cmp_en[2] [*4]) else $error("comparator on in blanking");

   // Amplitude path
   logic [smc_pkg::ADC_W-1:0] adc_out_r;
   logic [smc_pkg::KVAL_W-1:0] bemf_r;
   logic lso_r;
   logic [smc_pkg::KVAL_W-1:0] amp_r;
   logic [5:0] vs_factor;
   logic [5:0] th_factor;
   logic [smc_pkg::KVAL_W-1:0] bemf_nxt;
   logic [smc_pkg::KVAL_W-1:0] amp_nxt;

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
         adc_out_r <= '0;
      else if (pwm_period_i)
         adc_out_r <= adc_code_i;
   end

   always_comb
   begin
      case (phase_i)
         smc_pkg::SMC_STOPPED: bemf_nxt = '0;
         smc_pkg::SMC_DECEL: bemf_nxt = bemf_curve(amp_cfg_i.speed,
            amp_cfg_i.int_speed, amp_cfg_i.bemf_start_slope,
            amp_cfg_i.bemf_final_slope_decel);
         default: bemf_nxt = bemf_curve(amp_cfg_i.speed,
            amp_cfg_i.int_speed, amp_cfg_i.bemf_start_slope,
            amp_cfg_i.bemf_final_slope_accel);
      endcase
   end

   // Linear about mid-scale: a divider would cost far more area
   assign vs_factor = amp_cfg_i.supply_comp_enable ?
      smc_pkg::VS_FULL - {1'b0, adc_out_r} : smc_pkg::VS_UNITY;
   assign th_factor = smc_pkg::TH_UNITY +
      {2'b00, amp_cfg_i.thermal_factor};

   always_comb
   begin
      logic [8:0] base_sum;
      logic [14:0] p1;
      logic [16:0] p2;
      logic [19:0] p3;
      base_sum = {1'b0, amp_cfg_i.kval_base} + {1'b0, bemf_r};
      p1 = 15'(base_sum) * 15'(vs_factor);
      p2 = 17'(p1 >> smc_pkg::VS_SHIFT) * 17'(th_factor);
      p3 = 20'(p2 >> smc_pkg::TH_SHIFT) * 20'(amp_cfg_i.microstep);
      p3 = p3 >> smc_pkg::USTEP_SHIFT;
      if (p3 > 20'(smc_pkg::KVAL_MAX))
         amp_nxt = smc_pkg::KVAL_MAX;
      else
         amp_nxt = p3[smc_pkg::KVAL_W-1:0];
   end

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         bemf_r <= '0;
         lso_r <= 1'b0;
         amp_r <= '0;
      end
      else
      begin
         bemf_r <= bemf_nxt;
         lso_r <= amp_cfg_i.low_speed_opt_enable && phase_i !=
            smc_pkg::SMC_STOPPED && amp_cfg_i.speed <
            {8'h00, amp_cfg_i.min_speed};
         amp_r <= amp_nxt;
      end
   end

   assign profile_min_speed_o = amp_cfg_i.low_speed_opt_enable ?
      '0 : amp_cfg_i.min_speed;
   assign low_speed_opt_active_o = lso_r;
   assign bemf_term_o = bemf_r;
   assign adc_out_o = adc_out_r;
   assign supply_comp_factor_o = vs_factor;
   assign drive_amp_o = amp_r;

   chk_adc_sample: assert property (@(posedge mclk_i) disable iff (reset_i)
      pwm_period_i |=> adc_out_r == $past(adc_code_i))
      else $error("ADC not sampled on PWM period");
   chk_stop_bemf: assert property (@(posedge mclk_i) disable iff (reset_i)
      phase_i == smc_pkg::SMC_STOPPED |=> bemf_r == '0)
      else $error("bemf applied while stopped");
   chk_lso_speed: assert property (@(posedge mclk_i) disable iff (reset_i)
      lso_r |-> $past(amp_cfg_i.speed) < {8'h00, $past(amp_cfg_i.min_speed)})
      else $error("low speed opt above threshold");

   // Serial slave
   logic cs_n_f;
   logic cs_rise;
   logic cs_fall;
   logic ck_rise;
   logic ck_fall;
   logic sdi_f;
   logic [7:0] shift_r;
   logic [3:0] bits_r;
   logic sdo_r;
   logic [7:0] rx_r;
   logic rx_valid_r;
   logic frame_ok;
   logic sdi_dummy_unused;
   logic rise_unused;
   logic fall_unused;

   smc_pin_sync #(
      .WIDTH(3),
      .INIT(3'b100)
   ) u_pin_sync (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .pin_i({spi_cs_n_i, spi_ck_i, spi_sdi_i}),
      .level_o({cs_n_f, sdi_dummy_unused, sdi_f}),
      .rise_o({cs_rise, ck_rise, rise_unused}),
      .fall_o({cs_fall, ck_fall, fall_unused})
   );

   assign frame_ok = bits_r == 4'(smc_pkg::FRAME_BITS);
   assign status_clear = cs_rise && frame_ok &&
      shift_r == smc_pkg::STATUS_READ_OPCODE;

   // Shift stage: what comes in on SDI leaves on SDO one byte later
   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         shift_r <= smc_pkg::IDLE_REPLY;
         bits_r <= '0;
      end
      else if (cs_rise)
      begin
         bits_r <= '0;
         if (status_clear)
            shift_r <= {stall_a_n_r, stall_b_n_r, 6'h00};
         else if (reply_load_i)
            shift_r <= reply_byte_i;
         else
            shift_r <= smc_pkg::IDLE_REPLY;
      end
      else if (cs_n_f && reply_load_i)
         shift_r <= reply_byte_i;
      else if (!cs_n_f && ck_rise)
      begin
         shift_r <= {shift_r[6:0], sdi_f};
         if (bits_r != 4'hf)
            bits_r <= bits_r + 4'h1;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
         sdo_r <= 1'b0;
      else if (cs_fall || (!cs_n_f && ck_fall))
         sdo_r <= shift_r[7];
   end

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rx_r <= '0;
         rx_valid_r <= 1'b0;
      end
      else
      begin
         rx_valid_r <= cs_rise && frame_ok;
         if (cs_rise && frame_ok)
            rx_r <= shift_r;
      end
   end

   assign spi_sdo_o = sdo_r;
   assign spi_sdo_oe_n_o = cs_n_f;
   assign rx_byte_o = rx_r;
   assign rx_valid_o = rx_valid_r;

   chk_sdo_hiz: assert property (@(posedge mclk_i) disable iff (reset_i)
      cs_n_f |-> spi_sdo_oe_n_o) else $error("SDO driven deselected");
   chk_msb_out: assert property (@(posedge mclk_i) disable iff (reset_i)
      (!cs_n_f && ck_fall) |=> spi_sdo_o == $past(shift_r[7]))
      else $error("SDO not MSB of shift stage");
   chk_idle_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
      (cs_rise && !status_clear && !reply_load_i) |=> shift_r == 8'h00)
      else $error("idle reply not zero");
   chk_shift_in: assert property (@(posedge mclk_i) disable iff (reset_i)
      (!cs_n_f && ck_rise && !cs_rise) |=>
      shift_r == {$past(shift_r[6:0]), $past(sdi_f)})
      else $error("SDI not shifted on rising clock");
endmodule

//--- smc_pkg.sv
/*
 * Shared constants and carrier types for the stall, amplitude and serial
 * port logic of the stepper controller.
 * Assumes a single 25 MHz core clock; all times are converted here.
 */
package smc_pkg;

   // Core clock
   localparam int CLK_PERIOD_NS = 40;

   // Stall threshold: 32 levels of 31.25 mV, sensed voltage LSB = step/8
   localparam int STALL_LEVELS = 32;
   localparam int STALL_TH_W = 5;
   localparam int VDS_W = 8;
   localparam int VDS_LSB_PER_STEP = 8;
   localparam int HALF_BRIDGES = 4;

   // Blanking: 125 ns per setting step, rounded up to whole cycles
   localparam int BLANK_STEP_NS = 125;
   localparam int BLANK_STEP_CYC =
      (BLANK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_SEL_W = 3;
   localparam int BLANK_CNT_W = 6;

   // Amplitude arithmetic
   localparam int SPEED_W = 20;
   localparam int MIN_SPEED_W = 12;
   localparam int INT_SPEED_W = 14;
   localparam int KVAL_W = 8;
   localparam int ADC_W = 5;
   localparam int THERM_W = 4;
   localparam int BEMF_SHIFT = 16;
   localparam logic [5:0] VS_UNITY = 6'h10;
   localparam logic [5:0] VS_FULL = 6'h20;
   localparam int VS_SHIFT = 4;
   localparam logic [5:0] TH_UNITY = 6'h20;
   localparam int TH_SHIFT = 5;
   localparam int USTEP_SHIFT = 8;
   localparam logic [7:0] KVAL_MAX = 8'hff;

   // Serial port
   localparam int FRAME_BITS = 8;
   localparam logic [7:0] IDLE_REPLY = 8'h00;
   localparam logic [7:0] STATUS_READ_OPCODE = 8'hf0;

   typedef enum logic [1:0] {
      SMC_STOPPED = 2'b00,
      SMC_ACCEL = 2'b01,
      SMC_DECEL = 2'b10,
      SMC_RUN = 2'b11
   } smc_phase_type;

   // Half-bridge order: 0,1 = bridge A; 2,3 = bridge B
   typedef struct packed {
      logic [HALF_BRIDGES-1:0] hiz;
      logic [HALF_BRIDGES-1:0] ls_on;
      logic [HALF_BRIDGES-1:0] commut;
      logic [HALF_BRIDGES-1:0][VDS_W-1:0] vds;
   } smc_bridge_type;

   typedef struct packed {
      logic [KVAL_W-1:0] kval_base;
      logic [SPEED_W-1:0] speed;
      logic [MIN_SPEED_W-1:0] min_speed;
      logic low_speed_opt_enable;
      logic [INT_SPEED_W-1:0] int_speed;
      logic [KVAL_W-1:0] bemf_start_slope;
      logic [KVAL_W-1:0] bemf_final_slope_accel;
      logic [KVAL_W-1:0] bemf_final_slope_decel;
      logic supply_comp_enable;
      logic [THERM_W-1:0] thermal_factor;
      logic [KVAL_W-1:0] microstep;
   } smc_amp_cfg_type;

endpackage

//--- smc_pin_sync.sv
/*
 * Three-flop pin synchroniser with filtered level and edge pulses.
 * Assumes inputs are asynchronous to mclk_i; a change is accepted only
 * once the second and third stages agree.
 */
`timescale 1ns/10ps
module smc_pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
)(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] rise_o,
   output logic [WIDTH-1:0] fall_o
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] level_r;
   logic [WIDTH-1:0] agree;

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         s1_r <= INIT;
         s2_r <= INIT;
         s3_r <= INIT;
      end
      else
      begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign agree = ~(s2_r ^ s3_r);

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
         level_r <= INIT;
      else
         level_r <= (agree & s3_r) | (~agree & level_r);
   end

   assign level_o = level_r;
   assign rise_o = agree & s3_r & ~level_r;
   assign fall_o = agree & ~s3_r & level_r;
endmodule

//--- smc_spi_host.sv
/*
 * Host-side serial master model for the stepper controller slave port.
 * Assumes the slave samples on rising clock edges and updates its output
 * after falling ones; pins are driven on the model's own time base.
 */
`timescale 1ns/10ps
module smc_spi_host #(
   parameter int HALF_NS = 160,
   parameter int DESEL_NS = 800
)(
   output logic cs_n_o,
   output logic ck_o,
   output logic sdi_o,
   input wire logic sdo_i,
   input wire logic sdo_oe_n_i
);
   logic sdo_line;

   // A released output reads as high impedance on the line
   assign sdo_line = sdo_oe_n_i ? 1'bz : sdo_i;

   initial
   begin
      cs_n_o = 1'b1;
      ck_o = 1'b0;
      sdi_o = 1'b0;
   end

   // Clock idles low and stands still outside frames
   task automatic xfer(input logic [7:0] tx, input int nbits,
      output logic [7:0] rx);
      rx = 8'h00;
      // Odd offset keeps link edges away from core clock edges
      #13;
      cs_n_o = 1'b0;
      for (int i = 0; i < nbits; i++)
      begin
         sdi_o = tx[7-i];
         #((i == 0) ? 2 * HALF_NS : HALF_NS);
         ck_o = 1'b1;
         // Late sampling leaves the slave a full period to settle
         #(HALF_NS);
         rx = {rx[6:0], sdo_line};
         ck_o = 1'b0;
      end
      // Data line no longer holds its last value once released
      sdi_o = ~sdi_o;
      #(HALF_NS);
      cs_n_o = 1'b1;
      #(DESEL_NS);
   endtask
endmodule

//--- testbench.sv
/*
 * Self-checking bench for smc_core: reset, then amplitude rows in a loop,
 * then converter, stall, blanking and serial cases by hand.
 * Assumes smc_spi_host as the far side and a 25 MHz core clock.
 */
`timescale 1ns/10ps
module testbench;
   typedef struct packed {
      smc_pkg::smc_amp_cfg_type cfg;
      logic [1:0] ph;
      logic [4:0] adc;
      logic [7:0] bemf;
      logic [7:0] amp;
      logic lso;
      logic [5:0] vs;
   } smc_row_type;

   // Cfg: base,speed,min,lso,int,start,fin acc,fin dec,vs en,therm,ustep
   smc_row_type rows [10] = '{
      '{'{8'h40,20'h10000,12'h100,1'b0,14'h0,8'h08,8'h10,8'h20,1'b0,4'h0,
         8'h80},2'b01,5'h00,8'h10,8'h28,1'b0,6'h10},
      '{'{8'h40,20'h10000,12'h100,1'b0,14'h0,8'h08,8'h10,8'h20,1'b0,4'h0,
         8'h80},2'b10,5'h00,8'h20,8'h30,1'b0,6'h10},
      '{'{8'h40,20'h10000,12'h100,1'b0,14'h0,8'h08,8'h10,8'h20,1'b0,4'h0,
         8'h80},2'b11,5'h00,8'h10,8'h28,1'b0,6'h10},
      '{'{8'h40,20'h10000,12'h100,1'b0,14'h0,8'h08,8'h10,8'h20,1'b0,4'h0,
         8'h80},2'b00,5'h00,8'h00,8'h20,1'b0,6'h10},
      '{'{8'h40,20'h02000,12'h100,1'b1,14'h3fff,8'h40,8'h10,8'h20,1'b0,
         4'h0,8'h80},2'b01,5'h00,8'h08,8'h24,1'b0,6'h10},
      '{'{8'h40,20'h00800,12'hfff,1'b1,14'h0,8'h08,8'h10,8'h20,1'b0,4'h0,
         8'h80},2'b01,5'h00,8'h00,8'h20,1'b1,6'h10},
      '{'{8'h40,20'h00800,12'hfff,1'b1,14'h0,8'h08,8'h10,8'h20,1'b0,4'h0,
         8'h80},2'b00,5'h00,8'h00,8'h20,1'b0,6'h10},
      '{'{8'h40,20'h0,12'h100,1'b0,14'h0,8'h08,8'h10,8'h20,1'b1,4'h8,
         8'h80},2'b00,5'h08,8'h00,8'h3c,1'b0,6'h18},
      '{'{8'h40,20'h0,12'h100,1'b0,14'h0,8'h08,8'h10,8'h20,1'b0,4'h8,
         8'h80},2'b00,5'h08,8'h00,8'h28,1'b0,6'h10},
      '{'{8'h40,20'h0,12'h100,1'b0,14'h0,8'h08,8'h10,8'h20,1'b1,4'h0,
         8'h80},2'b00,5'h00,8'h00,8'h40,1'b0,6'h20}};
   logic [4:0] ths [3] = '{5'h00, 5'h0f, 5'h1e};

   logic mclk, reset_i, pwm, spi_cs_n, spi_ck, spi_sdi, reply_load;
   logic stall_a_n_o, stall_b_n_o, low_speed_opt_active_o, rx_valid_o;
   logic spi_sdo, spi_sdo_oe_n;
   logic [4:0] th, adc_code, adc_out_o;
   logic [2:0] blank_sel;
   logic [5:0] supply_comp_factor_o;
   logic [7:0] reply_byte, bemf_term_o, drive_amp_o, rx_byte_o, rxb;
   logic [11:0] profile_min_speed_o;
   smc_pkg::smc_bridge_type br;
   smc_pkg::smc_amp_cfg_type amp_cfg;
   smc_pkg::smc_phase_type phase;
   int n_fail = 0;
   int n_compared = 0;
   int n_rx = 0;

   smc_core u_smc_core (.mclk_i(mclk), .reset_i(reset_i), .bridge_i(br),
      .stall_th_i(th), .blank_sel_i(blank_sel), .amp_cfg_i(amp_cfg),
      .phase_i(phase), .pwm_period_i(pwm), .adc_code_i(adc_code),
      .spi_cs_n_i(spi_cs_n), .spi_ck_i(spi_ck), .spi_sdi_i(spi_sdi),
      .reply_load_i(reply_load), .reply_byte_i(reply_byte),
      .stall_a_n_o(stall_a_n_o), .stall_b_n_o(stall_b_n_o),
      .profile_min_speed_o(profile_min_speed_o),
      .low_speed_opt_active_o(low_speed_opt_active_o),
      .bemf_term_o(bemf_term_o), .adc_out_o(adc_out_o),
      .supply_comp_factor_o(supply_comp_factor_o),
      .drive_amp_o(drive_amp_o), .spi_sdo_o(spi_sdo),
      .spi_sdo_oe_n_o(spi_sdo_oe_n), .rx_byte_o(rx_byte_o),
      .rx_valid_o(rx_valid_o));

   smc_spi_host u_smc_spi_host (.cs_n_o(spi_cs_n), .ck_o(spi_ck),
      .sdi_o(spi_sdi), .sdo_i(spi_sdo), .sdo_oe_n_i(spi_sdo_oe_n));

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   always @(posedge mclk)
      if (rx_valid_o === 1'b1)
         n_rx++;

   task automatic report_and_stop;
      if (n_fail == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic cmp_val(input string nm, input logic [11:0] e,
      input logic [11:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_bit(input string nm, input logic e, input logic g);
      cmp_val(nm, 12'(e), 12'(g));
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic setv(input int i, input logic [7:0] v);
      @(posedge mclk);
      br.vds[i] <= v;
      cyc(3);
   endtask

   initial
   begin
      // Sized from 18 frames of about 4 us plus the row loop
      #1000000;
      n_fail++;
      report_and_stop();
   end

   initial
   begin
      reset_i = 1'b1;
      br = '{hiz: 4'h0, ls_on: 4'hf, commut: 4'h0, vds: '0};
      th = 5'h0f;
      blank_sel = 3'h1;
      amp_cfg = '0;
      phase = smc_pkg::SMC_STOPPED;
      pwm = 1'b0;
      adc_code = 5'h00;
      reply_load = 1'b0;
      reply_byte = 8'h00;
      cyc(5);
      cmp_bit("stall_a_rst", 1'b1, stall_a_n_o);
      cmp_bit("stall_b_rst", 1'b1, stall_b_n_o);
      cmp_bit("sdo_oe_n_rst", 1'b1, spi_sdo_oe_n);
      cmp_val("amp_rst", 12'(8'h00), 12'(drive_amp_o));
      repeat (5) @(posedge mclk);
      reset_i <= 1'b0;
      cyc(6);
      foreach (rows[k])
      begin
         @(posedge mclk);
         amp_cfg <= rows[k].cfg;
         phase <= smc_pkg::smc_phase_type'(rows[k].ph);
         adc_code <= rows[k].adc;
         pwm <= 1'b1;
         @(posedge mclk);
         pwm <= 1'b0;
         cyc(5);
         cmp_val("bemf", 12'(rows[k].bemf), 12'(bemf_term_o));
         cmp_val("amp", 12'(rows[k].amp), 12'(drive_amp_o));
         cmp_bit("lso", rows[k].lso, low_speed_opt_active_o);
         cmp_val("vs", 12'(rows[k].vs), 12'(supply_comp_factor_o));
         cmp_val("adc", 12'(rows[k].adc), 12'(adc_out_o));
         cmp_val("min", rows[k].cfg.low_speed_opt_enable ? 12'h000 :
            rows[k].cfg.min_speed, profile_min_speed_o);
      end
      // Converter holds its sample between period pulses
      @(posedge mclk);
      adc_code <= 5'h13;
      cyc(4);
      cmp_val("adc_hold", 12'(5'h00), 12'(adc_out_o));
      @(posedge mclk);
      pwm <= 1'b1;
      @(posedge mclk);
      pwm <= 1'b0;
      cyc(3);
      cmp_val("adc_new", 12'(5'h13), 12'(adc_out_o));
      // Threshold just at a level holds, one LSB over trips
      foreach (ths[k])
      begin
         @(posedge mclk);
         th <= ths[k];
         setv(0, {ths[k], 3'h0} + 8'h08);
         cmp_bit("stall_a_at", 1'b1, stall_a_n_o);
         setv(0, {ths[k], 3'h0} + 8'h09);
         cmp_bit("stall_a_over", 1'b0, stall_a_n_o);
         cmp_bit("stall_b_quiet", 1'b1, stall_b_n_o);
         setv(0, 8'h00);
         u_smc_spi_host.xfer(8'hf0, 8, rxb);
         cmp_bit("stall_a_clr", 1'b1, stall_a_n_o);
         u_smc_spi_host.xfer(8'h00, 8, rxb);
      end
      // Status read while still over threshold must not release
      @(posedge mclk);
      th <= 5'h0f;
      setv(1, 8'hff);
      u_smc_spi_host.xfer(8'hf0, 8, rxb);
      cmp_bit("stall_sticky", 1'b0, stall_a_n_o);
      u_smc_spi_host.xfer(8'h00, 8, rxb);
      cmp_val("status_a", 12'(8'h40), 12'(rxb));
      setv(1, 8'h00);
      cyc(20);
      cmp_bit("stall_wait", 1'b0, stall_a_n_o);
      u_smc_spi_host.xfer(8'hf0, 8, rxb);
      cmp_bit("stall_rel", 1'b1, stall_a_n_o);
      u_smc_spi_host.xfer(8'h00, 8, rxb);
      cmp_val("status_old", 12'(8'h40), 12'(rxb));
      u_smc_spi_host.xfer(8'h00, 8, rxb);
      cmp_val("idle_reply", 12'(8'h00), 12'(rxb));
      // Comparator gated by low side off and by high impedance
      @(posedge mclk);
      br.ls_on[1] <= 1'b0;
      br.hiz[3] <= 1'b1;
      setv(1, 8'hff);
      setv(3, 8'hff);
      cmp_bit("ls_off", 1'b1, stall_a_n_o);
      cmp_bit("hiz", 1'b1, stall_b_n_o);
      setv(1, 8'h00);
      @(posedge mclk);
      br.ls_on[1] <= 1'b1;
      br.hiz[3] <= 1'b0;
      cyc(3);
      cmp_bit("hiz_off", 1'b0, stall_b_n_o);
      setv(3, 8'h00);
      u_smc_spi_host.xfer(8'hf0, 8, rxb);
      u_smc_spi_host.xfer(8'h00, 8, rxb);
      cmp_val("status_b", 12'(8'h80), 12'(rxb));
      // Blanking of 8 cycles after commutation ends
      @(posedge mclk);
      br.commut[2] <= 1'b1;
      setv(2, 8'hff);
      cmp_bit("commut", 1'b1, stall_b_n_o);
      @(posedge mclk);
      br.commut[2] <= 1'b0;
      cyc(6);
      cmp_bit("blank", 1'b1, stall_b_n_o);
      cyc(5);
      cmp_bit("blank_end", 1'b0, stall_b_n_o);
      setv(2, 8'h00);
      u_smc_spi_host.xfer(8'hf0, 8, rxb);
      u_smc_spi_host.xfer(8'h00, 8, rxb);
      // Loaded reply comes back whole, command byte is received
      @(posedge mclk);
      reply_byte <= 8'ha5;
      reply_load <= 1'b1;
      @(posedge mclk);
      reply_load <= 1'b0;
      n_rx = 0;
      u_smc_spi_host.xfer(8'h3c, 8, rxb);
      cmp_val("reply", 12'(8'ha5), 12'(rxb));
      cmp_val("rx_byte", 12'(8'h3c), 12'(rx_byte_o));
      cmp_val("rx_count", 12'h001, 12'(n_rx));
      cmp_bit("sdo_off", 1'b1, spi_sdo_oe_n);
      // A short frame is refused and the reply falls back to zero
      @(posedge mclk);
      reply_load <= 1'b1;
      @(posedge mclk);
      reply_load <= 1'b0;
      u_smc_spi_host.xfer(8'hff, 5, rxb);
      cmp_val("short_count", 12'h001, 12'(n_rx));
      cmp_val("short_byte", 12'(8'h3c), 12'(rx_byte_o));
      u_smc_spi_host.xfer(8'h00, 8, rxb);
      cmp_val("after_short", 12'(8'h00), 12'(rxb));
      report_and_stop();
   end
endmodule
